// file: hw/scd_pkg.sv
// shared constants, types and command decoding for the serial command decoder
package scd_pkg;
  localparam int          CORE_HZ       = 250_000_000;
  localparam int          SCLK_MAX_HZ   = 25_000_000;
  localparam int          SCLK_HOST_HZ  = 5_000_000;
  // half period rounds up so the clock never runs faster than asked
  localparam int          SCLK_HALF_CYC = (CORE_HZ + 2 * SCLK_HOST_HZ - 1) / (2 * SCLK_HOST_HZ);
  localparam logic [7:0]  SETUP_RESET   = 8'h28;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [3:0]  RESULT_LEAD   = 4'h0;
  localparam logic [11:0] RESULT_SIGN   = 12'h800;
  localparam int          CONV_BIT      = 7;
  localparam int          SETUP_BIT     = 6;
  localparam int          AVG_BIT       = 5;
  localparam int          DAC_BIT       = 4;
  localparam int          RESET_BIT     = 3;
  localparam int          RESET_REQ_BIT = 2;
  localparam int          CK_HI         = 5;
  localparam int          CK_LO         = 4;
  localparam int          DIFF_HI       = 1;
  localparam int          DIFF_LO       = 0;
  localparam logic [1:0]  CLK_MODE_EXT  = 2'h3;
  localparam logic [1:0]  DIFF_UNI      = 2'h2;
  localparam logic [1:0]  DIFF_BIP      = 2'h3;
  localparam logic [7:0]  GPIO_CFG_CODE = 8'h03;
  localparam logic [7:0]  GPIO_WR_CODE  = 8'h02;
  localparam logic [7:0]  GPIO_RD_CODE  = 8'h01;
  localparam logic [7:0]  NOP_CODE      = 8'h00;
  localparam logic [4:0]  BITS_8        = 5'h08;
  localparam logic [4:0]  BITS_16       = 5'h10;
  localparam logic [4:0]  BITS_24       = 5'h18;
  localparam logic [3:0]  HREG_CTRL     = 4'h0;
  localparam logic [3:0]  HREG_TX       = 4'h1;
  localparam logic [3:0]  HREG_RX       = 4'h2;
  localparam logic [3:0]  HREG_STAT     = 4'h3;
  localparam int          CTRL_GO       = 0;
  localparam int          CTRL_LEN_LO   = 1;
  localparam int          CTRL_LEN_HI   = 2;
  localparam int          CTRL_FALL     = 3;

  typedef enum logic [3:0] {
    KIND_NONE, KIND_NOP, KIND_GPIO_RD, KIND_GPIO_WR, KIND_GPIO_CFG,
    KIND_RESET, KIND_DAC, KIND_AVG, KIND_SETUP, KIND_CONV
  } scd_kind_e;

  // highest set bit among bits 7 to 3 names the target register; lower codes must match exactly
  function automatic scd_kind_e cmd_kind(input logic [7:0] c);
    if (c[CONV_BIT])             return KIND_CONV;
    else if (c[SETUP_BIT])       return KIND_SETUP;
    else if (c[AVG_BIT])         return KIND_AVG;
    else if (c[DAC_BIT])         return KIND_DAC;
    else if (c[RESET_BIT])       return KIND_RESET;
    else if (c == GPIO_CFG_CODE) return KIND_GPIO_CFG;
    else if (c == GPIO_WR_CODE)  return KIND_GPIO_WR;
    else if (c == GPIO_RD_CODE)  return KIND_GPIO_RD;
    else if (c == NOP_CODE)      return KIND_NOP;
    else                         return KIND_NONE;
  endfunction

  // total transfer length, command byte included
  function automatic logic [4:0] kind_bits(input scd_kind_e k, input logic [7:0] c,
                                           input logic gp);
    case (k)
      KIND_SETUP:                             return c[DIFF_HI] ? BITS_16 : BITS_8;
      KIND_DAC:                               return BITS_24;
      KIND_GPIO_CFG, KIND_GPIO_WR, KIND_GPIO_RD: return gp ? BITS_16 : BITS_8;
      default:                                return BITS_8;
    endcase
  endfunction
endpackage

// file: hw/scd_link_if.sv
// four-wire serial link between the bus master and the decoder
`timescale 1ns/1ns
interface scd_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // undriven data out reads low at the master
  assign miso_line = miso_oe ? miso : 1'b0;

  modport host   (output cs_n, output sclk, output mosi, input miso_line);
  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
endinterface

// file: hw/scd_edge_sync.sv
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module scd_edge_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic core_clk, // core clock
  input  wire logic srst,     // synchronous reset
  input  wire logic async_in, // pin from another domain
  output logic      level,    // filtered level
  output logic      rise,     // one-cycle pulse on rise
  output logic      fall      // one-cycle pulse on fall
);
  logic s1;
  logic s2;
  logic s3;
  wire  agree = (s2 == s3);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1    <= IDLE_LEVEL;
      s2    <= IDLE_LEVEL;
      s3    <= IDLE_LEVEL;
      level <= IDLE_LEVEL;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1    <= async_in;
      s2    <= s1;
      s3    <= s2;
      level <= agree ? s3 : level;
      rise  <= agree & s3 & ~level;
      fall  <= agree & ~s3 & level;
    end
  end
endmodule

// file: hw/scd_device.sv
// device end: serial front end, command decoder and register dispatch
// What this block does
// - master uses matching polarity and phase
// - master keeps serial clock at most 25MHz
// - data in sampled on falling serial clock
// - modes 00/01/10 update data out on fall
// - mode 11 updates data out on rise
// - bipolar and temperature results two's complement
// - chip select fall starts, rise ends reception
// - every transaction opens with command byte, MSB first
// - command sets length and target
// - chip select high resets the interface
// - master holds chip select low whole transfer
// - DAC command followed by two payload bytes
// - GPIO write carries exactly one data byte
// - no-GPIO device ignores GPIO commands
// - bit 7 writes conversion register fields
// - bits 01 write setup register fields
// - setup mode selects next byte as mode register
// - bits 001 write averaging register fields
// - bits 00001 write reset register fields
// - low codes decode GPIO configure/write/read, no-op
// - one decoder dispatches to at most one target; a setup command with a mode byte writes the setup and a mode register
// - data out undriven while chip select high
// - setup resets to 28h, others to zero
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
module scd_device
  import scd_pkg::*;
#(
  parameter logic HAS_GPIO = 1'b1
) (
  input  wire logic   core_clk,           // core clock, 250 MHz
  input  wire logic   srst,               // synchronous reset, active high
  scd_link_if.device  link,               // serial link pins
  input  wire logic [11:0] result_code,   // converter result, offset binary
  input  wire logic   result_signed,      // result is bipolar or temperature
  input  wire logic [7:0]  gpio_read_value, // pin levels for a GPIO read
  output logic [7:0]  conversion_request, // conversion register
  output logic [7:0]  converter_setup,    // setup register
  output logic [7:0]  averaging_control,  // averaging register
  output logic [7:0]  soft_reset_control, // reset register
  output logic [7:0]  unipolar_mode,      // unipolar mode register
  output logic [7:0]  bipolar_mode,       // bipolar mode register
  output logic        conv_start,         // pulse: conversion register written
  output logic        soft_reset_pulse,   // pulse: reset requested
  output logic        dac_load,           // pulse: dac_word valid
  output logic [15:0] dac_word,           // DAC select and data
  output logic        gpio_cfg_load,      // pulse: configure byte valid
  output logic        gpio_wr_load,       // pulse: write byte valid
  output logic [7:0]  gpio_data,          // GPIO payload byte
  output logic        gpio_rd_req         // pulse: GPIO read started
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } scd_state_e;

  scd_state_e  st;
  scd_state_e  next_st;
  scd_kind_e   kind;
  logic [4:0]  cnt;
  logic [4:0]  total;
  logic [7:0]  cmd;
  logic [23:0] rx;
  logic [15:0] tx;
  logic        cs_lvl;
  logic        cs_rise;
  logic        cs_fall;
  logic        sclk_lvl;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        mosi_lvl;

  scd_edge_sync #(.IDLE_LEVEL(1'b1)) u_cs (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (link.cs_n),
    .level    (cs_lvl),
    .rise     (cs_rise),
    .fall     (cs_fall)
  );
  scd_edge_sync #(.IDLE_LEVEL(1'b0)) u_sclk (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (link.sclk),
    .level    (sclk_lvl),
    .rise     (sclk_rise),
    .fall     (sclk_fall)
  );
  scd_edge_sync #(.IDLE_LEVEL(1'b0)) u_mosi (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (link.mosi),
    .level    (mosi_lvl),
    .rise     (),
    .fall     ()
  );

  wire         sample    = sclk_fall & ~cs_lvl;
  wire [23:0]  rx_next   = {rx[22:0], mosi_lvl};
  wire [4:0]   cnt_next  = cnt + 5'h01;
  wire         cmd_done  = (st == ST_CMD) && sample && (cnt_next == BITS_8);
  wire [7:0]   cmd_byte  = rx_next[7:0];
  wire scd_kind_e new_kind = cmd_kind(cmd_byte);
  wire [4:0]   new_total = kind_bits(new_kind, cmd_byte, HAS_GPIO);
  wire         data_done = (st == ST_DATA) && sample && (cnt_next == total);
  wire         fin_short = cmd_done && (new_total == BITS_8);
  wire         finish    = fin_short || data_done;
  wire scd_kind_e fin_kind = cmd_done ? new_kind : kind;
  wire [7:0]   fin_cmd   = cmd_done ? cmd_byte : cmd;
  // at most one target sees a finished transaction
  wire         hit_conv  = finish && (fin_kind == KIND_CONV);
  wire         hit_avg   = finish && (fin_kind == KIND_AVG);
  wire         hit_rst   = finish && (fin_kind == KIND_RESET);
  wire         hit_setup = cmd_done && (new_kind == KIND_SETUP);
  wire         hit_mode  = data_done && (kind == KIND_SETUP);
  wire         hit_dac   = data_done && (kind == KIND_DAC);
  wire         gp_data   = data_done && HAS_GPIO;
  wire         hit_gcfg  = gp_data && (kind == KIND_GPIO_CFG);
  wire         hit_gwr   = gp_data && (kind == KIND_GPIO_WR);
  wire         hit_grd   = cmd_done && HAS_GPIO && (new_kind == KIND_GPIO_RD);
  wire         soft_rst  = hit_rst && fin_cmd[RESET_REQ_BIT];
  wire         ext_clk   = (converter_setup[CK_HI:CK_LO] == CLK_MODE_EXT);
  // in mode 11 the first rise must not shift away the bit shown at chip select fall
  wire         upd_fall  = ~ext_clk && sclk_fall && ~cs_lvl;
  wire         upd_rise  = ext_clk && sclk_rise && ~cs_lvl && (cnt != 5'h00);
  wire [11:0]  fmt_code  = result_signed ? (result_code ^ RESULT_SIGN) : result_code;
  // in mode 11 the next rise shifts once before the master samples, so the byte sits one lower
  wire [15:0]  grd_word  = {gpio_read_value, ZERO_BYTE} >> ext_clk;
  wire [15:0]  next_tx   = cs_fall  ? {RESULT_LEAD, fmt_code} :
                           hit_grd  ? grd_word :
                           (upd_fall || upd_rise) ? {tx[14:0], 1'b0} : tx;

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: next_st = cs_fall ? ST_CMD : ST_IDLE;
      ST_CMD:  next_st = fin_short ? ST_DONE : (cmd_done ? ST_DATA : ST_CMD);
      ST_DATA: next_st = data_done ? ST_DONE : ST_DATA;
      ST_DONE: next_st = ST_DONE;
      default: next_st = ST_IDLE;
    endcase
    if (cs_rise) begin
      next_st = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st    <= ST_IDLE;
      cnt   <= 5'h00;
      total <= BITS_8;
      kind  <= KIND_NONE;
      cmd   <= ZERO_BYTE;
      rx    <= 24'h000000;
    end else begin
      st    <= next_st;
      cnt   <= (cs_rise || cs_fall) ? 5'h00 : (sample ? cnt_next : cnt);
      rx    <= sample ? rx_next : rx;
      kind  <= cmd_done ? new_kind : kind;
      total <= cmd_done ? new_total : total;
      cmd   <= cmd_done ? cmd_byte : cmd;
    end
  end

  // data out: oe follows chip select so the pin floats between frames
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx           <= 16'h0000;
      link.miso    <= 1'b0;
      link.miso_oe <= 1'b0;
    end else begin
      tx           <= next_tx;
      link.miso    <= ~cs_lvl & next_tx[15];
      link.miso_oe <= ~cs_lvl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      conversion_request <= ZERO_BYTE;
      converter_setup    <= SETUP_RESET;
      averaging_control  <= ZERO_BYTE;
      soft_reset_control <= ZERO_BYTE;
      unipolar_mode      <= ZERO_BYTE;
      bipolar_mode       <= ZERO_BYTE;
    end else begin
      conversion_request <= hit_conv  ? fin_cmd  : conversion_request;
      converter_setup    <= hit_setup ? cmd_byte : converter_setup;
      averaging_control  <= hit_avg   ? fin_cmd  : averaging_control;
      soft_reset_control <= hit_rst   ? fin_cmd  : soft_reset_control;
      unipolar_mode      <= (hit_mode && cmd[DIFF_HI:DIFF_LO] == DIFF_UNI) ?
                            rx_next[7:0] : unipolar_mode;
      bipolar_mode       <= (hit_mode && cmd[DIFF_HI:DIFF_LO] == DIFF_BIP) ?
                            rx_next[7:0] : bipolar_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      conv_start       <= 1'b0;
      soft_reset_pulse <= 1'b0;
      dac_load         <= 1'b0;
      dac_word         <= 16'h0000;
      gpio_cfg_load    <= 1'b0;
      gpio_wr_load     <= 1'b0;
      gpio_data        <= ZERO_BYTE;
      gpio_rd_req      <= 1'b0;
    end else begin
      conv_start       <= hit_conv;
      soft_reset_pulse <= soft_rst;
      dac_load         <= hit_dac;
      dac_word         <= hit_dac ? rx_next[15:0] : dac_word;
      gpio_cfg_load    <= hit_gcfg;
      gpio_wr_load     <= hit_gwr;
      gpio_data        <= (hit_gcfg || hit_gwr) ? rx_next[7:0] : gpio_data;
      gpio_rd_req      <= hit_grd;
    end
  end
endmodule

// file: hw/scd_host.sv
// host end: register-driven bus master for the serial link
`timescale 1ns/1ns
module scd_host
  import scd_pkg::*;
(
  input  wire logic        core_clk,  // core clock, 250 MHz
  input  wire logic        srst,      // synchronous reset, active high
  input  wire logic [3:0]  reg_addr,  // register address
  input  wire logic [31:0] reg_wdata, // write data
  input  wire logic        reg_wr,    // write strobe
  input  wire logic        reg_rd,    // read strobe
  output logic [31:0]      reg_rdata, // read data, cycle after strobe
  scd_link_if.host         link       // serial link pins
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_LEAD = 6'b000010,
    H_HIGH = 6'b000100,
    H_LOW  = 6'b001000,
    H_TAIL = 6'b010000,
    H_GAP  = 6'b100000
  } scd_hstate_e;

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);

  scd_hstate_e hs;
  logic [7:0]  div;
  logic [4:0]  bits;
  logic [4:0]  nbits;
  logic [23:0] tx_sh;
  logic [23:0] tx_data;
  logic [23:0] rx_sh;
  logic [23:0] rx_data;
  logic        fall_mode;
  logic        miso_lvl;

  scd_edge_sync #(.IDLE_LEVEL(1'b0)) u_miso (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (link.miso_line),
    .level    (miso_lvl),
    .rise     (),
    .fall     ()
  );

  wire       busy     = (hs != H_IDLE);
  wire       tick     = busy && (div == HALF_LAST);
  wire [1:0] len      = reg_wdata[CTRL_LEN_HI:CTRL_LEN_LO];
  wire       go       = reg_wr && (reg_addr == HREG_CTRL) && reg_wdata[CTRL_GO] &&
                        ~busy && (len != 2'h0);
  wire       to_rise  = tick && (hs == H_LEAD || hs == H_LOW);
  wire       to_fall  = tick && (hs == H_HIGH);
  wire [4:0] bits_inc = bits + 5'h01;
  // mosi moves at the rise so it is steady round the falling sample edge
  wire       shift_tx = to_rise && (bits != 5'h00);
  wire       take_rx  = fall_mode ? to_fall : to_rise;
  wire [31:0] rd_mux  = (reg_addr == HREG_TX)   ? {8'h00, tx_data} :
                        (reg_addr == HREG_RX)   ? {8'h00, rx_data} :
                        (reg_addr == HREG_STAT) ? {31'h0, busy} : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hs <= H_IDLE;
    end else begin
      case (hs)
        H_IDLE:  hs <= go ? H_LEAD : H_IDLE;
        H_LEAD:  hs <= tick ? H_HIGH : H_LEAD;
        H_HIGH:  hs <= tick ? ((bits_inc == nbits) ? H_TAIL : H_LOW) : H_HIGH;
        H_LOW:   hs <= tick ? H_HIGH : H_LOW;
        H_TAIL:  hs <= tick ? H_GAP : H_TAIL;
        H_GAP:   hs <= tick ? H_IDLE : H_GAP;
        default: hs <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div       <= 8'h00;
      bits      <= 5'h00;
      nbits     <= BITS_8;
      tx_sh     <= 24'h000000;
      tx_data   <= 24'h000000;
      rx_sh     <= 24'h000000;
      rx_data   <= 24'h000000;
      fall_mode <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      div       <= (go || tick) ? 8'h00 : (busy ? div + 8'h01 : div);
      bits      <= go ? 5'h00 : (to_fall ? bits_inc : bits);
      nbits     <= go ? {len, 3'h0} : nbits;
      fall_mode <= go ? reg_wdata[CTRL_FALL] : fall_mode;
      tx_data   <= (reg_wr && reg_addr == HREG_TX && ~busy) ? reg_wdata[23:0] : tx_data;
      tx_sh     <= go ? tx_data : (shift_tx ? {tx_sh[22:0], 1'b0} : tx_sh);
      link.mosi <= go ? tx_data[23] : (shift_tx ? tx_sh[22] : link.mosi);
      link.cs_n <= go ? 1'b0 : ((tick && hs == H_TAIL) ? 1'b1 : link.cs_n);
      link.sclk <= to_rise ? 1'b1 : (to_fall ? 1'b0 : link.sclk);
      rx_sh     <= go ? 24'h000000 : (take_rx ? {rx_sh[22:0], miso_lvl} : rx_sh);
      rx_data   <= (tick && hs == H_TAIL) ? rx_sh : rx_data;
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule

// file: verif/scd_chk.sv
// concurrent checks on the serial link between the host and device ends
`timescale 1ns/1ns
module scd_chk
  import scd_pkg::*;
(
  input wire logic core_clk,  // core clock
  input wire logic srst,      // synchronous reset
  input wire logic cs_n,      // chip select
  input wire logic sclk,      // serial clock
  input wire logic mosi,      // data to device
  input wire logic miso,      // device data out
  input wire logic miso_oe,   // device drive enable
  input wire logic miso_line  // resolved data out
);
  logic       sclk_q;
  logic       cs_q;
  logic [5:0] hi_cnt;
  logic [4:0] n_fall;
  logic [3:0] age;
  wire        sclk_fall = sclk_q & ~sclk;
  wire        moved     = (sclk != sclk_q) | (cs_n != cs_q);

  // age counts cycles since any serial clock or chip select edge, so data-out moves can be tied to one
  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    cs_q   <= cs_n;
    hi_cnt <= (srst || !sclk) ? 6'h00 : hi_cnt + {5'h00, hi_cnt != 6'h3f};
    n_fall <= (srst || cs_n) ? 5'h00 : n_fall + {4'h0, sclk_fall};
    age    <= (srst || moved) ? 4'h0 : age + {3'h0, age != 4'hf};
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_frame_open;
    $fell(cs_n) ##1 !cs_n [*7];
  endsequence
  sequence s_cs_quiet;
    cs_n [*8];
  endsequence

  a_oe_on_start: assert property (s_frame_open |-> miso_oe)
    else $error("data out not driven inside frame");
  a_oe_off_idle: assert property (s_cs_quiet |-> !miso_oe && !miso_line)
    else $error("data out driven while deselected");
  a_oe_drop_end: assert property ($rose(cs_n) |-> ##[1:8] !miso_oe)
    else $error("data out still driven after deselect");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  a_mosi_at_fall: assert property ($fell(sclk) |-> $stable(mosi))
    else $error("data in moved at sampling edge");
  a_half_period: assert property ($fell(sclk) |-> hi_cnt == SCLK_HALF_CYC)
    else $error("serial clock high phase wrong length");
  a_frame_len: assert property ($rose(cs_n) |-> n_fall inside {5'd8, 5'd16, 5'd24})
    else $error("frame not a whole number of bytes");
  a_miso_at_edge: assert property ($changed(miso) |-> age <= 4'h8)
    else $error("data out changed away from a link edge");
  a_miso_settled: assert property ($changed(sclk) && !cs_n |-> $stable(miso_line))
    else $error("data out moving at a clock edge");
  cover property (s_frame_open);
endmodule

// file: verif/serial_command_decoder_tb.sv
// self-checking bench: host end driving device end, plus a bit-banged second device
`timescale 1ns/1ns
module serial_command_decoder_tb
  import scd_pkg::*;
;
  typedef struct packed {
    logic [23:0] tx;
    logic [1:0]  nb;
    logic [47:0] regs;
    logic [15:0] dac;
    logic [7:0]  gp;
    logic [5:0]  pm;
  } scd_row_s;

  logic        core_clk, srst, reg_wr, reg_rd, result_signed, clr_pm;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx;
  logic [11:0] result_code;
  logic [7:0]  gpio_read_value, gpio_data, gpio2, conv2;
  logic [7:0]  r_cv, r_su, r_av, r_rs, r_un, r_bp;
  logic [15:0] dac_word;
  wire  [5:0]  pls, pls2;
  logic [5:0]  pm, pm2;
  int          n_errors, tests_run, cyc;
  wire  [47:0] regs = {r_cv, r_su, r_av, r_rs, r_un, r_bp};

  // pulse order: conversion, reset, dac, gpio cfg, gpio wr, gpio rd
  scd_row_s rows [13] = '{
    '{24'hb50000, 2'h1, 48'hb52800000000, 16'h0000, 8'h00, 6'h20},
    '{24'h640000, 2'h1, 48'hb56400000000, 16'h0000, 8'h00, 6'h00},
    '{24'h66a500, 2'h2, 48'hb5660000a500, 16'h0000, 8'h00, 6'h00},
    '{24'h673c00, 2'h2, 48'hb5670000a53c, 16'h0000, 8'h00, 6'h00},
    '{24'h3b0000, 2'h1, 48'hb5673b00a53c, 16'h0000, 8'h00, 6'h00},
    '{24'h0b0000, 2'h1, 48'hb5673b0ba53c, 16'h0000, 8'h00, 6'h00},
    '{24'h1f1234, 2'h3, 48'hb5673b0ba53c, 16'h1234, 8'h00, 6'h08},
    '{24'h035a00, 2'h2, 48'hb5673b0ba53c, 16'h1234, 8'h5a, 6'h04},
    '{24'h02c300, 2'h2, 48'hb5673b0ba53c, 16'h1234, 8'hc3, 6'h02},
    '{24'h010000, 2'h2, 48'hb5673b0ba53c, 16'h1234, 8'hc3, 6'h01},
    '{24'h000000, 2'h1, 48'hb5673b0ba53c, 16'h1234, 8'hc3, 6'h00},
    '{24'h050000, 2'h1, 48'hb5673b0ba53c, 16'h1234, 8'hc3, 6'h00},
    '{24'h0c0000, 2'h1, 48'h002800000000, 16'h1234, 8'hc3, 6'h10}
  };

  scd_link_if l1 ();
  scd_link_if l2 ();

  scd_host scd_host_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(l1));

  scd_device #(.HAS_GPIO(1'b1)) scd_device_inst (.core_clk(core_clk), .srst(srst), .link(l1),
    .result_code(result_code), .result_signed(result_signed), .gpio_read_value(gpio_read_value),
    .conversion_request(r_cv), .converter_setup(r_su), .averaging_control(r_av),
    .soft_reset_control(r_rs), .unipolar_mode(r_un), .bipolar_mode(r_bp),
    .conv_start(pls[5]), .soft_reset_pulse(pls[4]), .dac_load(pls[3]), .dac_word(dac_word),
    .gpio_cfg_load(pls[2]), .gpio_wr_load(pls[1]), .gpio_data(gpio_data), .gpio_rd_req(pls[0]));

  // second device has no gpio and is driven by hand so frames can be cut short
  scd_device #(.HAS_GPIO(1'b0)) scd_device_inst2 (.core_clk(core_clk), .srst(srst), .link(l2),
    .result_code(result_code), .result_signed(result_signed), .gpio_read_value(gpio_read_value),
    .conversion_request(conv2), .converter_setup(), .averaging_control(),
    .soft_reset_control(), .unipolar_mode(), .bipolar_mode(),
    .conv_start(pls2[5]), .soft_reset_pulse(pls2[4]), .dac_load(pls2[3]), .dac_word(),
    .gpio_cfg_load(pls2[2]), .gpio_wr_load(pls2[1]), .gpio_data(gpio2), .gpio_rd_req(pls2[0]));

  scd_chk scd_chk_inst (.core_clk(core_clk), .srst(srst), .cs_n(l1.cs_n), .sclk(l1.sclk),
    .mosi(l1.mosi), .miso(l1.miso), .miso_oe(l1.miso_oe), .miso_line(l1.miso_line));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    pm  <= clr_pm ? 6'h00 : (pm | pls);
    pm2 <= clr_pm ? 6'h00 : (pm2 | pls2);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic clr;
    clr_pm <= 1'b1;
    @(posedge core_clk);
    clr_pm <= 1'b0;
  endtask

  task automatic xfer(input logic [23:0] tx, input logic [1:0] nb, input logic fm,
                      output logic [31:0] d);
    logic [31:0] s;
    int          k;
    clr();
    wr(HREG_TX, {8'h00, tx});
    wr(HREG_CTRL, {28'h0, fm, nb, 1'b1});
    s = 32'h1;
    k = 0;
    while (s[0] !== 1'b0 && k < 4000) begin
      rd(HREG_STAT, s);
      k++;
    end
    rd(HREG_RX, d);
  endtask

  // link period 80 ns; data in changes at the rise, the device takes it at the fall
  task automatic bang(input logic [23:0] d, input int n);
    l2.cs_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      l2.mosi <= d[23-i];
      l2.sclk <= 1'b1;
      repeat (10) @(posedge core_clk);
      l2.sclk <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
    l2.cs_n <= 1'b1;
    l2.mosi <= ~d[24-n];
    repeat (20) @(posedge core_clk);
  endtask

  initial begin
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    srst = 1'b1;
    clr_pm = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    result_code = 12'ha53;
    result_signed = 1'b0;
    gpio_read_value = 8'h96;
    l2.cs_n = 1'b1;
    l2.sclk = 1'b0;
    l2.mosi = 1'b0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    clr_pm <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("reset regs", regs, 48'h002800000000);
    rd(HREG_STAT, rx);
    check("status idle", rx, 32'h0);
    rd(4'h7, rx);
    check("unmapped read", rx, 32'h0);
    for (int i = 0; i < 13; i++) begin
      xfer(rows[i].tx, rows[i].nb, 1'b0, rx);
      check("registers", regs, rows[i].regs);
      check("dac_word", dac_word, rows[i].dac);
      check("gpio_data", gpio_data, rows[i].gp);
      check("pulses", pm, rows[i].pm);
    end
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        result_signed <= s[0];
        xfer(m[0] ? 24'h700000 : 24'h640000, 2'h1, 1'b0, rx);
        xfer(24'h000000, 2'h2, m[0], rx);
        check("result word", rx[15:0], s[0] ? 16'h0253 : 16'h0a53);
      end
    end
    xfer(24'h010000, 2'h2, 1'b1, rx);
    check("gpio read word", rx[15:0], 16'h0296);
    clr();
    bang(24'h1f1234, 16);
    bang(24'h930000, 8);
    check("cut frame", conv2, 8'h93);
    check("cut frame pulses", pm2, 6'h20);
    clr();
    bang(24'h02ff00, 16);
    check("no gpio", {gpio2, pm2}, 14'h0000);
    wrap_up();
  end
endmodule
